// ---- quadrature_encoder_counter.sv ----
// Purpose: quadrature decoding, counting, reference loads and exposure latch
// Assumes: expose_start, expose_len and intensity come from the clock domain
// Notes:   encoder and sync pins pass a three-stage synchronizer
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module quadrature_encoder_counter
   import qenc_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
) (
   input  wire logic                         clock,
   input  wire logic                         rst_n,
   input  wire logic [ADDR_W-1:0]            s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   input  wire logic [ADDR_W-1:0]            s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [31:0]                       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   input  wire logic [NUM_CH-1:0]            enc_a,
   input  wire logic [NUM_CH-1:0]            enc_b,
   input  wire logic [NUM_CH-1:0]            enc_ref,
   input  wire logic                         sync_in,
   output logic                              sync_out,
   output logic                              rs422_enable,
   input  wire logic                         expose_start,
   input  wire logic [23:0]                  expose_len,
   input  wire logic [1:0]                   intensity,
   output logic                              meas_start,
   output logic                              meas_valid,
   output logic [NUM_CH-1:0][31:0]           meas_count
);
   typedef struct packed {
      logic [3:0]              ctrl;
      logic [31:0]             rate;
      logic [NUM_CH-1:0][3:0]  cfg;
      logic [NUM_CH-1:0][31:0] maxv, preset, count, latch;
      logic [NUM_CH-1:0][2:0]  a_s, b_s, z_s;
      logic [NUM_CH-1:0]       first_seen, a_f, b_f, z_f;
      logic [2:0]              sync_s;
      logic                    sync_f;
      logic [27:0]             acc;
      logic [2:0]              sync_hold;
      logic                    sync_o, meas_start;
      logic [23:0]             mid_cnt;
      logic                    mid_run, meas_valid;
      logic [1:0]              intensity;
      logic                    aw_got, w_got;
      logic [ADDR_W-1:0]       awaddr;
      logic [31:0]             wdata;
      logic [3:0]              wstrb;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    rvalid;
      logic [31:0]             rdata;
      logic [1:0]              rresp;
   } state_s;

   state_s s;
   state_s next_s;

   // counted edge and direction of one step: {counted, up}
   function automatic logic [1:0] step(input logic [1:0] mode,
                                       input logic a_old, input logic b_old,
                                       input logic a_new, input logic b_new);
      logic ca, cb, up, cnt;
      ca = a_old ^ a_new;
      cb = b_old ^ b_new;
      up = a_new ^ b_old;
      case (interp_e'(mode))
         INTERP_SINGLE: cnt = ca & ~cb & ~b_new;
         INTERP_DOUBLE: cnt = ca & ~cb;
         default:       cnt = ca ^ cb;
      endcase
      return {cnt, up};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] val,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = val[i*8 +: 8];
         end
      end
      return r;
   endfunction
   function automatic logic [1:0] addr_chan(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] d;
      d = a - OFS_CH_BASE;
      return d[CH_SHIFT +: 2];
   endfunction
   function automatic logic [4:0] addr_sub(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] d;
      d = a - OFS_CH_BASE;
      return d[4:0];
   endfunction

   logic [1:0]        n_enc, st, ch;
   logic [31:0]       rate_max, wval, cmd;
   logic [ADDR_W-1:0] waddr;
   logic [3:0]        wstb;
   logic [28:0]       acc_sum;
   logic [4:0]        sub;
   logic              sync_active, aw_hs, w_hs, do_write, wr_ok, tick;
   logic              sync_rise, start, az, bz, zz, z_rise, ld_ref;

   assign s_axi_awready = ~s.aw_got & ~s.bvalid;
   assign s_axi_wready  = ~s.w_got & ~s.bvalid;
   assign s_axi_arready = ~s.rvalid;
   assign s_axi_bvalid  = s.bvalid;
   assign s_axi_bresp   = s.bresp;
   assign s_axi_rvalid  = s.rvalid;
   assign s_axi_rdata   = s.rdata;
   assign s_axi_rresp   = s.rresp;
   assign sync_out      = s.sync_o;
   assign meas_start    = s.meas_start;
   assign meas_valid    = s.meas_valid;
   assign meas_count    = s.latch;
   assign rs422_enable  = (s.ctrl[1:0] != 2'h2) | ~LARGE_VARIANT;

   always_comb begin
      next_s = s;
      // effective channel count and sync mode
      n_enc = (s.ctrl[1:0] == 2'h0 || !LARGE_VARIANT) ? 2'h1 :
              s.ctrl[1:0];
      sync_active = (n_enc != 2'h2) &
                    (sync_e'(s.ctrl[3:2]) inside {SYNC_MASTER, SYNC_SLAVE});
      rate_max = LARGE_VARIANT ? RATE_MAX_HZ : RATE_MAX_SMALL_HZ;
      // write channel: address and data in either order
      aw_hs = s_axi_awvalid & s_axi_awready;
      w_hs  = s_axi_wvalid & s_axi_wready;
      if (aw_hs) begin
         next_s.aw_got = 1'b1;
         next_s.awaddr = s_axi_awaddr;
      end
      if (w_hs) begin
         next_s.w_got = 1'b1;
         next_s.wdata = s_axi_wdata;
         next_s.wstrb = s_axi_wstrb;
      end
      waddr = s.aw_got ? s.awaddr : s_axi_awaddr;
      wval  = s.w_got ? s.wdata : s_axi_wdata;
      wstb  = s.w_got ? s.wstrb : s_axi_wstrb;
      do_write = (s.aw_got | aw_hs) & (s.w_got | w_hs) & ~s.bvalid;
      wr_ok = 1'b0;
      cmd = 32'h0;
      ch  = addr_chan(waddr);
      sub = addr_sub(waddr);
      if (do_write) begin
         next_s.aw_got = 1'b0;
         next_s.w_got  = 1'b0;
         next_s.bvalid = 1'b1;
         wr_ok = 1'b1;
         case (waddr)
            OFS_CTRL: next_s.ctrl = 4'(merge({28'h0, s.ctrl}, wval, wstb));
            OFS_RATE: begin
               next_s.rate = merge(s.rate, wval, wstb);
               if (next_s.rate < RATE_MIN_HZ) begin
                  next_s.rate = RATE_MIN_HZ;
               end else if (next_s.rate > rate_max) begin
                  next_s.rate = rate_max;
               end
            end
            OFS_STATUS: ;
            OFS_CMD: cmd = wval;
            default: begin
               wr_ok = 1'b0;
               if (waddr >= OFS_CH_BASE && int'(ch) < NUM_CH) begin
                  wr_ok = 1'b1;
                  case (sub)
                     OFS_CFG: next_s.cfg[ch] =
                        4'(merge({28'h0, s.cfg[ch]}, wval, wstb));
                     OFS_MAX: next_s.maxv[ch] = merge(s.maxv[ch], wval, wstb);
                     OFS_PRESET: next_s.preset[ch] =
                        merge(s.preset[ch], wval, wstb);
                     OFS_COUNT: ;
                     OFS_LATCH: ;
                     default: wr_ok = 1'b0;
                  endcase
               end
            end
         endcase
         next_s.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s.bvalid & s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      // measuring rate generator
      acc_sum = {1'b0, s.acc} + {1'b0, s.rate[27:0]};
      tick = acc_sum >= CLK_HZ;
      next_s.acc = tick ? 28'(acc_sum - CLK_HZ) : acc_sum[27:0];
      // sync pin: change counts once stages two and three agree
      next_s.sync_s = {s.sync_s[1:0], sync_in};
      if (s.sync_s[1] == s.sync_s[2]) begin
         next_s.sync_f = s.sync_s[2];
      end
      sync_rise = next_s.sync_f & ~s.sync_f;
      start = (sync_active && sync_e'(s.ctrl[3:2]) == SYNC_SLAVE) ?
              sync_rise : tick;
      next_s.meas_start = start;
      next_s.sync_hold = (s.sync_hold != 3'h0) ? s.sync_hold - 3'h1 : 3'h0;
      if (sync_active && sync_e'(s.ctrl[3:2]) == SYNC_MASTER && tick) begin
         next_s.sync_hold = SYNC_HOLD_CYC;
      end
      next_s.sync_o = sync_active & (next_s.sync_hold != 3'h0);
      // intensity only reported, never gates measuring
      next_s.intensity = intensity;
      // latch counts at half the exposure length
      next_s.meas_valid = 1'b0;
      if (expose_start) begin
         next_s.mid_run = 1'b1;
         next_s.mid_cnt = expose_len >> 1;
      end else if (s.mid_run) begin
         if (s.mid_cnt == 24'h0) begin
            next_s.mid_run = 1'b0;
            next_s.meas_valid = 1'b1;
            next_s.latch = s.count;
         end else begin
            next_s.mid_cnt = s.mid_cnt - 24'h1;
         end
      end
      // per channel decode and count
      for (int i = 0; i < NUM_CH; i++) begin
         next_s.a_s[i] = {s.a_s[i][1:0], enc_a[i]};
         next_s.b_s[i] = {s.b_s[i][1:0], enc_b[i]};
         next_s.z_s[i] = {s.z_s[i][1:0], enc_ref[i]};
         az = (s.a_s[i][1] == s.a_s[i][2]) ? s.a_s[i][2] : s.a_f[i];
         bz = (s.b_s[i][1] == s.b_s[i][2]) ? s.b_s[i][2] : s.b_f[i];
         zz = (s.z_s[i][1] == s.z_s[i][2]) ? s.z_s[i][2] : s.z_f[i];
         next_s.a_f[i] = az;
         next_s.b_f[i] = bz;
         next_s.z_f[i] = zz;
         z_rise = zz & ~s.z_f[i];
         if (cmd[CMD_REFRST_LSB + i]) begin
            next_s.z_f[i] = 1'b1;
            z_rise = 1'b0;
         end
         st = step(s.cfg[i][1:0], s.a_f[i], s.b_f[i], az, bz);
         if (i >= int'(n_enc)) begin
            st = 2'b00;
            z_rise = 1'b0;
         end
         if (n_enc == 2'h3 && i < 2) begin
            z_rise = 1'b0;
         end
         case (ref_e'(s.cfg[i][3:2]))
            REF_ONCE: ld_ref = z_rise & ~s.first_seen[i];
            REF_ALL:  ld_ref = z_rise;
            default:  ld_ref = 1'b0;
         endcase
         if (cmd[CMD_REARM_LSB + i]) begin
            next_s.first_seen[i] = 1'b0;
         end
         if (ld_ref) begin
            next_s.first_seen[i] = 1'b1;
         end
         if (cmd[CMD_SET_LSB + i] || ld_ref) begin
            next_s.count[i] = s.preset[i];
         end else if (st[1]) begin
            if (st[0]) begin
               next_s.count[i] = (s.count[i] >= s.maxv[i]) ? 32'h0 :
                                 s.count[i] + 32'h1;
            end else begin
               next_s.count[i] = (s.count[i] == 32'h0) ? s.maxv[i] :
                                 s.count[i] - 32'h1;
            end
         end
      end
      // read channel
      if (s.rvalid & s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid & s_axi_arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = RESP_OKAY;
         next_s.rdata = 32'h0;
         ch  = addr_chan(s_axi_araddr);
         sub = addr_sub(s_axi_araddr);
         case (s_axi_araddr)
            OFS_CTRL: next_s.rdata = {28'h0, s.ctrl};
            OFS_RATE: next_s.rdata = s.rate;
            OFS_STATUS: begin
               next_s.rdata[1:0] = s.intensity;
               next_s.rdata[ST_RS422_BIT] = rs422_enable;
               next_s.rdata[ST_SYNC_BIT] = sync_active;
               next_s.rdata[ST_SEEN_LSB +: NUM_CH] = s.first_seen;
            end
            OFS_CMD: ;
            default: begin
               next_s.rresp = RESP_SLVERR;
               if (s_axi_araddr >= OFS_CH_BASE && int'(ch) < NUM_CH) begin
                  next_s.rresp = RESP_OKAY;
                  case (sub)
                     OFS_CFG:    next_s.rdata = {28'h0, s.cfg[ch]};
                     OFS_MAX:    next_s.rdata = s.maxv[ch];
                     OFS_PRESET: next_s.rdata = s.preset[ch];
                     OFS_COUNT:  next_s.rdata = s.count[ch];
                     OFS_LATCH:  next_s.rdata = s.latch[ch];
                     default:    next_s.rresp = RESP_SLVERR;
                  endcase
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s            <= '0;
         s.ctrl       <= CTRL_RESET;
         s.rate       <= RATE_RESET;
         s.z_f        <= '1;
         for (int i = 0; i < NUM_CH; i++) begin
            s.cfg[i]    <= CFG_RESET;
            s.maxv[i]   <= MAX_RESET;
            s.preset[i] <= PRESET_RESET;
            s.count[i]  <= PRESET_RESET;
         end
      end else begin
         s <= next_s;
      end
   end
endmodule
`default_nettype wire

// ---- qenc_pkg.sv ----
// Purpose: constants, register map and types of the quadrature encoder counter
// Assumes: AXI4-Lite register access, 200 MHz clock, up to three channels
// Notes:   all offsets are byte addresses of aligned 32-bit words
package qenc_pkg;
   localparam int          NUM_CH        = 3;
   localparam int          ADDR_W        = 8;
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_RATE      = 8'h04;
   localparam logic [7:0]  OFS_STATUS    = 8'h08;
   localparam logic [7:0]  OFS_CMD       = 8'h0C;
   localparam logic [7:0]  OFS_CH_BASE   = 8'h10;
   localparam int          CH_SHIFT      = 5;
   localparam logic [4:0]  OFS_CFG       = 5'h00;
   localparam logic [4:0]  OFS_MAX       = 5'h04;
   localparam logic [4:0]  OFS_PRESET    = 5'h08;
   localparam logic [4:0]  OFS_COUNT     = 5'h0C;
   localparam logic [4:0]  OFS_LATCH     = 5'h10;
   localparam int          CMD_SET_LSB   = 0;
   localparam int          CMD_REARM_LSB = 4;
   localparam int          CMD_REFRST_LSB = 8;
   localparam int          ST_RS422_BIT  = 2;
   localparam int          ST_SYNC_BIT   = 3;
   localparam int          ST_SEEN_LSB   = 4;
   localparam logic [3:0]  CTRL_RESET    = 4'h1;
   localparam logic [3:0]  CFG_RESET     = 4'h0;
   localparam logic [31:0] MAX_RESET     = 32'hFFFF_FFFF;
   localparam logic [31:0] PRESET_RESET  = 32'h0000_0000;
   localparam logic [31:0] RATE_RESET    = 32'h0000_03E8;
   localparam logic [31:0] RATE_MIN_HZ   = 32'h0000_0064;
   localparam logic [31:0] RATE_MAX_HZ   = 32'h0000_61A8;
   localparam logic [31:0] RATE_MAX_SMALL_HZ = 32'h0000_1F40;
   localparam int          CLK_PERIOD_NS = 5;
   localparam logic [28:0] CLK_HZ        = 29'(1000000000 / CLK_PERIOD_NS);
   localparam logic [2:0]  SYNC_HOLD_CYC = 3'h4;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   typedef enum logic [1:0] {INTERP_SINGLE, INTERP_DOUBLE, INTERP_QUAD,
                             INTERP_QUAD_ALT} interp_e;
   typedef enum logic [1:0] {REF_NONE, REF_ONCE, REF_ALL, REF_NONE_ALT} ref_e;
   typedef enum logic [1:0] {SYNC_OFF, SYNC_MASTER, SYNC_SLAVE,
                             SYNC_OFF_ALT} sync_e;
   typedef enum logic [1:0] {INT_OK, INT_LOW, INT_SAT, INT_SAT_ALT} intensity_e;
endpackage

// ---- qenc_monitor.sv ----
// Purpose: output assertions for the quadrature encoder counter
// Assumes: exposure length 4 in checks; sync_in pulses only in slave mode
// Notes:   bound to every counter instance
`timescale 1ns/1ps
`default_nettype none
module qenc_monitor
   import qenc_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic                    rst_n,
   input  wire logic                    expose_start,
   input  wire logic [23:0]             expose_len,
   input  wire logic                    meas_valid,
   input  wire logic [NUM_CH-1:0][31:0] meas_count,
   input  wire logic                    meas_start,
   input  wire logic                    sync_in,
   input  wire logic                    sync_out,
   input  wire logic                    rs422_enable
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   chk_latch_mid: assert property (
      expose_start && expose_len == 24'h4 |-> ##4 meas_valid)
      else $error("latch missed exposure midpoint");
   chk_latch_early: assert property (
      expose_start && expose_len == 24'h4 |=> !meas_valid [*3])
      else $error("latch came too early");
   chk_count_hold: assert property (
      !meas_valid |-> $stable(meas_count))
      else $error("latched count moved without a latch");
   chk_sync_width: assert property (
      $rose(sync_out) |-> sync_out [*4] ##1 !sync_out)
      else $error("sync pulse width wrong");
   chk_sync_start: assert property (
      $rose(sync_out) |-> meas_start)
      else $error("sync pulse without measurement start");
   chk_slave_start: assert property (
      $rose(sync_in) && !sync_out |-> ##[4:5] meas_start)
      else $error("slave did not start on sync input");
   chk_start_gap: assert property (
      meas_start |=> !meas_start [*8])
      else $error("measurement starts too close");
   chk_two_enc: assert property (
      !rs422_enable |-> !sync_out)
      else $error("sync active with two encoders");

   cover property (meas_valid);
   cover property ($rose(sync_out));
   cover property (!rs422_enable && meas_start);
endmodule

bind quadrature_encoder_counter qenc_monitor MON (.clock, .rst_n,
   .expose_start, .expose_len, .meas_valid, .meas_count, .meas_start,
   .sync_in, .sync_out, .rs422_enable);
`default_nettype wire

// ---- enc_model.sv ----
// Purpose: behavioural quadrature encoders with reference mark
// Assumes: callers wait for each task to return
// Notes:   tracks hold eight cycles per step so the counter settles
`timescale 1ns/1ps
`default_nettype none
module enc_model
   import qenc_pkg::*;
(
   input  wire logic         clock,
   output logic [NUM_CH-1:0] a,
   output logic [NUM_CH-1:0] b,
   output logic [NUM_CH-1:0] mark
);
   logic [1:0] ph [NUM_CH];

   initial begin
      a = '0;
      b = '0;
      mark = '0;
      foreach (ph[i]) ph[i] = 2'h0;
   end

   // quarter step; forward walks 00,10,11,01 on A,B, one track at a time
   task automatic step(input int ch, input bit fwd);
      @(posedge clock);
      ph[ch] = fwd ? ph[ch] + 2'h1 : ph[ch] - 2'h1;
      a[ch] <= ^ph[ch];
      b[ch] <= ph[ch][1];
      repeat (8) @(posedge clock);
   endtask

   // mark high then low, eight cycles each
   task automatic pulse(input int ch);
      @(posedge clock);
      mark[ch] <= 1'b1;
      repeat (8) @(posedge clock);
      mark[ch] <= 1'b0;
      repeat (8) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Purpose: self-checking bench for the quadrature encoder counter
// Assumes: channel 0 carries the encoder traffic
// Notes:   registers reached through AXI4-Lite tasks
`timescale 1ns/1ps
`default_nettype none
module tb
   import qenc_pkg::*;
();
   logic                    clock, rst_n, sync_in, expose_start;
   logic                    s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic                    s_axi_arvalid, s_axi_rready, s_axi_awready;
   logic                    s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic                    s_axi_rvalid, sync_out, rs422_enable;
   logic                    meas_start, meas_valid;
   logic [1:0]              s_axi_bresp, s_axi_rresp, intensity;
   logic [3:0]              s_axi_wstrb;
   logic [7:0]              s_axi_awaddr, s_axi_araddr;
   logic [23:0]             expose_len;
   logic [31:0]             s_axi_wdata, s_axi_rdata;
   logic [NUM_CH-1:0]       enc_a, enc_b, enc_ref;
   logic [NUM_CH-1:0][31:0] meas_count;
   int                      err_total, n_tests;

   quadrature_encoder_counter DUT (.clock, .rst_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .enc_a,
      .enc_b, .enc_ref, .sync_in, .sync_out, .rs422_enable, .expose_start,
      .expose_len, .intensity, .meas_start, .meas_valid, .meas_count);
   enc_model enc (.clock, .a(enc_a), .b(enc_b), .mark(enc_ref));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tmo(input logic ok);
      chk(32'(ok), 32'h1);
      if (ok !== 1'b1) wrap_up();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] m = 4'hF,
                     input logic [1:0] e = RESP_OKAY);
      int i;
      logic ta, tw, tk;
      logic [1:0] rp;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= m;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      i = 0;
      do begin
         @(negedge clock);
         ta = s_axi_awready;
         tw = s_axi_wready;
         tk = s_axi_bvalid;
         rp = s_axi_bresp;
         @(posedge clock);
         if (ta === 1'b1) s_axi_awvalid <= 1'b0;
         if (tw === 1'b1) s_axi_wvalid <= 1'b0;
         i++;
      end while (tk !== 1'b1 && i < 64);
      s_axi_bready <= 1'b0;
      tmo(tk);
      chk(32'(rp), 32'(e));
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      int i;
      logic ta, tv;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      i = 0;
      do begin
         @(negedge clock);
         ta = s_axi_arready;
         tv = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clock);
         if (ta === 1'b1) s_axi_arvalid <= 1'b0;
         i++;
      end while (tv !== 1'b1 && i < 64);
      s_axi_rready <= 1'b0;
      tmo(tv);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(d, e);
   endtask

   task automatic mv(input int n, input bit f);
      repeat (n) enc.step(0, f);
   endtask

   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      rchk(OFS_CTRL, 32'h1);
      rchk(8'h1C, 32'h0);
      rchk(8'h14, 32'hFFFF_FFFF);
      wr(8'h14, 32'h0, 4'h1);
      rchk(8'h14, 32'hFFFF_FF00);
      wr(8'h14, 32'hFFFF_FFFF);
      wr(8'h70, 32'h1, 4'hF, RESP_SLVERR);
      enc.step(1, 1'b1);
      rchk(8'h3C, 32'h0);
      wr(OFS_RATE, 32'h0000_7530);
      rchk(OFS_RATE, 32'h0000_61A8);
      wr(OFS_RATE, 32'h0000_0032);
      rchk(OFS_RATE, 32'h0000_0064);
      rd(8'h70, d, r);
      chk(32'(r), 32'h2);
      chk(d, 32'h0);
   endtask

   task automatic t_interp();
      for (int m = 0; m < 3; m++) begin
         wr(8'h10, 32'(m));
         mv(4, 1'b1);
         rchk(8'h1C, 32'h1 << m);
         mv(4, 1'b0);
         rchk(8'h1C, 32'h0);
      end
   endtask

   task automatic t_ref();
      wr(8'h18, 32'h5);
      wr(8'h10, 32'h4);
      enc.pulse(0);
      rchk(8'h1C, 32'h5);
      mv(4, 1'b1);
      enc.pulse(0);
      rchk(8'h1C, 32'h6);
      wr(OFS_CMD, 32'h10);
      enc.pulse(0);
      rchk(8'h1C, 32'h5);
      mv(4, 1'b1);
      wr(OFS_CMD, 32'h1);
      rchk(8'h1C, 32'h5);
      wr(8'h10, 32'h8);
      for (int k = 0; k < 2; k++) begin
         mv(4, 1'b1);
         enc.pulse(0);
         rchk(8'h1C, 32'h5);
      end
      wr(OFS_CTRL, 32'h3);
      mv(4, 1'b1);
      enc.pulse(0);
      rchk(8'h1C, 32'h6);
      wr(OFS_CTRL, 32'h1);
      wr(8'h10, 32'h0);
      enc.pulse(0);
      rchk(8'h1C, 32'h6);
   endtask

   task automatic t_wrap();
      wr(8'h18, 32'h0);
      wr(8'h14, 32'h3);
      wr(8'h10, 32'h2);
      wr(OFS_CMD, 32'h1);
      mv(3, 1'b1);
      rchk(8'h1C, 32'h3);
      mv(1, 1'b1);
      rchk(8'h1C, 32'h0);
      mv(1, 1'b0);
      rchk(8'h1C, 32'h3);
   endtask

   task automatic t_latch();
      @(posedge clock);
      expose_start <= 1'b1;
      expose_len <= 24'h4;
      @(posedge clock);
      expose_start <= 1'b0;
      repeat (3) @(posedge clock);
      @(negedge clock);
      chk(32'(meas_valid), 32'h1);
      chk(meas_count[0], 32'h3);
      mv(1, 1'b1);
      rchk(8'h20, 32'h3);
      wr(8'h14, 32'hFFFF_FFFF);
   endtask

   task automatic t_sync();
      int i, hits, starts;
      logic [31:0] d;
      logic [1:0] r;
      wr(OFS_RATE, 32'h0000_61A8);
      wr(OFS_CTRL, 32'h5);
      i = 0;
      while (sync_out !== 1'b1 && i < 9000) begin
         @(negedge clock);
         i++;
      end
      tmo(sync_out);
      repeat (8) @(posedge clock);
      wr(OFS_CTRL, 32'h9);
      @(posedge clock);
      sync_in <= 1'b1;
      i = 0;
      do begin
         @(negedge clock);
         i++;
      end while (meas_start !== 1'b1 && i < 12);
      tmo(meas_start);
      @(posedge clock);
      sync_in <= 1'b0;
      intensity <= 2'h2;
      wr(OFS_CTRL, 32'h6);
      rd(OFS_STATUS, d, r);
      chk(d & 32'hF, 32'h2);
      chk(32'(rs422_enable), 32'h0);
      hits = 0;
      starts = 0;
      for (i = 0; i < 9000; i++) begin
         @(negedge clock);
         if (sync_out !== 1'b0) hits++;
         if (meas_start === 1'b1) starts++;
      end
      chk(32'(hits), 32'h0);
      chk(32'(starts != 0), 32'h1);
      wr(OFS_CTRL, 32'h1);
   endtask

   initial begin
      rst_n = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, sync_in, expose_start} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, expose_len} = 72'h0;
      s_axi_wstrb = 4'hF;
      intensity = 2'h0;
      err_total = 0;
      n_tests = 0;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      t_regs();
      t_interp();
      t_ref();
      t_wrap();
      t_latch();
      t_sync();
      wrap_up();
   end
endmodule
`default_nettype wire
